// ==== include/i2c_intr_pkg.sv ====
// Constants for the I2C interrupt mask and raw status block.
// Assumes a 32-bit APB register bus and a byte engine that reports bus events as pulses.
`default_nettype none

package i2c_intr_pkg;

    // ------------------------------------------------------------
    // Register byte addresses.
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_DATA_CMD  = 32'h50001310; // Transmit push and receive pop.
    localparam logic [31:0] ADDR_MASKED    = 32'h5000132C; // Masked status, read only.
    localparam logic [31:0] ADDR_MASK      = 32'h50001330; // Interrupt enable mask.
    localparam logic [31:0] ADDR_RAW       = 32'h50001334; // Unmasked status, read only.
    localparam logic [31:0] ADDR_CLR_ALL   = 32'h50001340; // Read clears every flag.
    localparam logic [31:0] ADDR_CLR_RDREQ = 32'h50001350; // Read clears read request.
    localparam logic [31:0] ADDR_CLR_ABORT = 32'h50001354; // Read clears transmit abort.
    localparam logic [31:0] ADDR_CLR_ACT   = 32'h5000135C; // Read clears activity.
    localparam logic [31:0] ADDR_CLR_GC    = 32'h50001368; // Read clears general call.
    localparam logic [31:0] ADDR_ABORT_WHY = 32'h50001380; // Abort reason, read only.

    // ------------------------------------------------------------
    // Status bit positions.
    // ------------------------------------------------------------
    localparam int BIT_GC      = 11; // General call acknowledged.
    localparam int BIT_START   = 10; // Start or repeated start seen.
    localparam int BIT_STOP    = 9;  // Stop seen.
    localparam int BIT_ACT     = 8;  // Sticky bus activity.
    localparam int BIT_RXDONE  = 7;  // Slave transmit ended by a NACK.
    localparam int BIT_ABORT   = 6;  // Transmit aborted.
    localparam int BIT_RDREQ   = 5;  // Remote master asks for data.
    localparam int BIT_TXOVER  = 3;  // Transmit buffer overflow.
    localparam int BIT_RXOVER  = 1;  // Receive buffer overflow.
    localparam int BIT_RXUNDER = 0;  // Receive buffer underflow.

    // ------------------------------------------------------------
    // Widths, reset values and depths.
    // ------------------------------------------------------------
    localparam int          REG_W     = 16;       // Width of each register.
    localparam int          ENTRY_W   = 9;        // Command bit plus data byte.
    localparam int          FIFO_N    = 32;       // Entries per buffer.
    localparam int          PTR_W     = 5;        // Buffer pointer width.
    localparam logic [5:0]  FIFO_FULL = 6'h20;    // Count meaning full.
    localparam logic [15:0] MASK_RST  = 16'h08FF; // Mask value after reset.
    localparam logic [15:0] MASK_WR   = 16'h0FFF; // Writable mask bits.
    localparam logic [15:0] RAW_RST   = 16'h0000; // Status value after reset.

endpackage

`default_nettype wire

// ==== rtl/i2c_byte_fifo.sv ====
// Thirty-two entry flip-flop buffer used for the transmit and receive paths.
// Assumes push and pop are single-cycle requests; a flush wins over both.
`default_nettype none
`timescale 1ns/10ps

module i2c_byte_fifo (
    // Clock and reset.
    input  wire logic                                i_clk,
    input  wire logic                                i_rst,
    // Control.
    input  wire logic                                i_flush,
    input  wire logic                                i_push,
    input  wire logic [i2c_intr_pkg::ENTRY_W-1:0]    i_wdata,
    input  wire logic                                i_pop,
    // Status and head entry.
    output logic      [i2c_intr_pkg::ENTRY_W-1:0]    o_rdata,
    output logic      [5:0]                          o_count,
    output logic                                     o_full,
    output logic                                     o_empty
);

    // ------------------------------------------------------------
    // Storage and pointers.
    // ------------------------------------------------------------
    logic [i2c_intr_pkg::ENTRY_W-1:0] mem_q [i2c_intr_pkg::FIFO_N]; // Entries.
    logic [i2c_intr_pkg::ENTRY_W-1:0] mem_d [i2c_intr_pkg::FIFO_N]; // Next entries.
    logic [i2c_intr_pkg::PTR_W-1:0]   wp_q, wp_d;                   // Write index.
    logic [i2c_intr_pkg::PTR_W-1:0]   rp_q, rp_d;                   // Read index.
    logic [5:0]                       cnt_q, cnt_d;                 // Fill level.
    logic                             do_push, do_pop;              // Accepted moves.

    assign o_full  = (cnt_q == i2c_intr_pkg::FIFO_FULL);
    assign o_empty = (cnt_q == 6'h00);
    assign o_count = cnt_q;
    assign o_rdata = mem_q[rp_q];
    // A push to a full buffer and a pop from an empty one are dropped here.
    assign do_push = i_push & ~o_full;
    assign do_pop  = i_pop & ~o_empty;

    // Next pointers and contents; flush only resets indices, data is left stale.
    always_comb begin
        mem_d = mem_q;
        wp_d  = wp_q;
        rp_d  = rp_q;
        cnt_d = cnt_q;
        if (i_flush) begin
            wp_d  = '0;
            rp_d  = '0;
            cnt_d = 6'h00;
        end else begin
            if (do_push) begin
                mem_d[wp_q] = i_wdata;
                wp_d        = wp_q + 5'h01;
            end
            if (do_pop) begin
                rp_d = rp_q + 5'h01;
            end
            cnt_d = cnt_q + {5'h00, do_push} - {5'h00, do_pop};
        end
    end

    // Control registers.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= 6'h00;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    // Data storage needs no reset because the count guards it.
    always_ff @(posedge i_clk) begin
        mem_q <= mem_d;
    end

endmodule // i2c_byte_fifo

`default_nettype wire

// ==== rtl/i2c_intr_status.sv ====
// Interrupt mask, raw status flags, buffers and clock hold for an I2C controller.
// Assumes the byte engine reports bus events as one-cycle pulses on I_REF_CLK.
//
// Functional notes
// - Twelve mask bits, reserved high, defined reset.
// - General call flag set on acknowledged address.
// - General call data enters receive buffer normally.
// - Start or restart sets status bit ten.
// - Stop sets status bit nine.
// - Sticky activity cleared by disable, reads, reset.
// - Slave transmit NACK sets done bit seven.
// - Transmit abort sets bit six, reason kept.
// - Abort flushes transmit buffer until cleared.
// - Read request sets bit five, holds clock.
// - Read request flag cleared by clear read.
// - Overflow flags at thirty-two stored entries.
`default_nettype none
`timescale 1ns/10ps

module i2c_intr_status (
    // Clock and reset.
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RESET,
    // APB slave.
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [31:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // Byte engine events.
    input  wire logic        I_CTRL_ENABLE,
    input  wire logic        I_BROADCAST_ADDRESS_SEEN_ACK,
    input  wire logic        I_START_SEEN,
    input  wire logic        I_STOP_SEEN,
    input  wire logic        I_BUS_BUSY,
    input  wire logic        I_SLV_TX_NACK,
    input  wire logic        I_TX_ABORT,
    input  wire logic [15:0] I_ABORT_REASON,
    input  wire logic        I_RD_REQ,
    // Byte engine data.
    input  wire logic        I_RX_VALID,
    input  wire logic [7:0]  I_RX_DATA,
    input  wire logic        I_TX_POP,
    output logic      [8:0]  O_TX_DATA,
    output logic             O_TX_STROBE,
    // Bus control and interrupt.
    output logic             O_SCL_HOLD,
    output logic             O_INTR
);

    // ------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------

    // Sticky flag update where a set in the clearing cycle still lands.
    function automatic logic set_wins(input logic q, input logic s, input logic c);
        return s | (q & ~c);
    endfunction

    // ------------------------------------------------------------
    // Bus phase decode.
    // ------------------------------------------------------------
    logic setup;   // Setup phase of any transfer.
    logic acc;     // Access phase completing this edge.
    logic rd_acc;  // Completing read.
    logic wr_acc;  // Completing write.

    assign setup  = I_PSEL & ~I_PENABLE;
    assign acc    = I_PSEL & I_PENABLE & O_PREADY;
    assign rd_acc = acc & ~I_PWRITE;
    assign wr_acc = acc & I_PWRITE;

    // Side-effect strobes; reads clear flags only when the transfer completes.
    logic clr_all, clr_rd, clr_ab, clr_act, clr_gc; // Clear-on-read strobes.
    logic wr_mask, wr_data, rd_data;                // Data path strobes.
    logic dis;                                      // Controller disabled.

    assign clr_all = rd_acc & (I_PADDR == i2c_intr_pkg::ADDR_CLR_ALL);
    assign clr_rd  = rd_acc & (I_PADDR == i2c_intr_pkg::ADDR_CLR_RDREQ);
    assign clr_ab  = rd_acc & (I_PADDR == i2c_intr_pkg::ADDR_CLR_ABORT);
    assign clr_act = rd_acc & (I_PADDR == i2c_intr_pkg::ADDR_CLR_ACT);
    assign clr_gc  = rd_acc & (I_PADDR == i2c_intr_pkg::ADDR_CLR_GC);
    assign wr_mask = wr_acc & (I_PADDR == i2c_intr_pkg::ADDR_MASK);
    assign wr_data = wr_acc & (I_PADDR == i2c_intr_pkg::ADDR_DATA_CMD);
    assign rd_data = rd_acc & (I_PADDR == i2c_intr_pkg::ADDR_DATA_CMD);
    assign dis     = ~I_CTRL_ENABLE;

    // ------------------------------------------------------------
    // State.
    // ------------------------------------------------------------
    logic [15:0] mask_q, mask_d;     // Interrupt enable mask.
    logic        gc_q, gc_d;         // General call flag.
    logic        st_q, st_d;         // Start flag.
    logic        sp_q, sp_d;         // Stop flag.
    logic        act_q, act_d;       // Activity flag.
    logic        rxd_q, rxd_d;       // Slave transmit done flag.
    logic        ab_q, ab_d;         // Transmit abort flag.
    logic        rr_q, rr_d;         // Read request flag.
    logic        txo_q, txo_d;       // Transmit overflow flag.
    logic        rxo_q, rxo_d;       // Receive overflow flag.
    logic        rxu_q, rxu_d;       // Receive underflow flag.
    logic [15:0] why_q, why_d;       // Reason of the last abort.
    logic        hold_q, hold_d;     // Clock stretch request.
    logic [15:0] raw;                // Unmasked status word.
    logic [15:0] masked;             // Masked status word.

    // ------------------------------------------------------------
    // Buffers.
    // ------------------------------------------------------------
    logic [8:0] tx_head, rx_head;    // Head entries.
    logic [5:0] tx_cnt;              // Transmit fill level.
    logic       tx_full, tx_empty;   // Transmit status.
    logic       rx_full, rx_empty;   // Receive status.
    logic       tx_push, rx_push;    // Accepted pushes.
    logic       tx_pop;              // Accepted engine fetch.

    // An abort refuses new bytes so a flushed buffer really stays empty.
    assign tx_push = wr_data & ~ab_q & ~tx_full;
    // Received bytes, general call data included, are stored alike.
    assign rx_push = I_RX_VALID & ~rx_full;
    // No fetch while aborted, so a stale head is never handed out before the flush lands.
    assign tx_pop  = I_TX_POP & ~tx_empty & ~ab_q;

    i2c_byte_fifo u_tx_fifo (
        .i_clk   (I_REF_CLK),
        .i_rst   (I_RESET),
        .i_flush (ab_q | dis),
        .i_push  (tx_push),
        .i_wdata (I_PWDATA[8:0]),
        .i_pop   (tx_pop),
        .o_rdata (tx_head),
        .o_count (tx_cnt),
        .o_full  (tx_full),
        .o_empty (tx_empty)
    );

    i2c_byte_fifo u_rx_fifo (
        .i_clk   (I_REF_CLK),
        .i_rst   (I_RESET),
        .i_flush (dis),
        .i_push  (rx_push),
        .i_wdata ({1'b0, I_RX_DATA}),
        .i_pop   (rd_data),
        .o_rdata (rx_head),
        .o_count (),
        .o_full  (rx_full),
        .o_empty (rx_empty)
    );

    // ------------------------------------------------------------
    // Status words.
    // ------------------------------------------------------------

    // Raw word; bits without a source here read as zero.
    always_comb begin
        raw                               = i2c_intr_pkg::RAW_RST;
        raw[i2c_intr_pkg::BIT_GC]         = gc_q;
        raw[i2c_intr_pkg::BIT_START]      = st_q;
        raw[i2c_intr_pkg::BIT_STOP]       = sp_q;
        raw[i2c_intr_pkg::BIT_ACT]        = act_q;
        raw[i2c_intr_pkg::BIT_RXDONE]     = rxd_q;
        raw[i2c_intr_pkg::BIT_ABORT]      = ab_q;
        raw[i2c_intr_pkg::BIT_RDREQ]      = rr_q;
        raw[i2c_intr_pkg::BIT_TXOVER]     = txo_q;
        raw[i2c_intr_pkg::BIT_RXOVER]     = rxo_q;
        raw[i2c_intr_pkg::BIT_RXUNDER]    = rxu_q;
    end

    // A mask bit of one lets its source through.
    assign masked = raw & mask_q;

    // ------------------------------------------------------------
    // Flag and mask next values.
    // ------------------------------------------------------------

    // Disabling clears the flags that only make sense while running.
    always_comb begin
        mask_d = wr_mask ? (I_PWDATA[15:0] & i2c_intr_pkg::MASK_WR) : mask_q;
        gc_d   = set_wins(gc_q, I_BROADCAST_ADDRESS_SEEN_ACK, dis | clr_gc | clr_all);
        st_d   = set_wins(st_q, I_START_SEEN, clr_all);
        sp_d   = set_wins(sp_q, I_STOP_SEEN, clr_all);
        act_d  = set_wins(act_q, I_BUS_BUSY, dis | clr_act | clr_all);
        rxd_d  = set_wins(rxd_q, I_SLV_TX_NACK, clr_all);
        ab_d   = set_wins(ab_q, I_TX_ABORT, clr_ab | clr_all);
        rr_d   = set_wins(rr_q, I_RD_REQ, clr_rd | clr_all);
        txo_d  = set_wins(txo_q, wr_data & tx_full & ~ab_q, dis | clr_all);
        rxo_d  = set_wins(rxo_q, I_RX_VALID & rx_full, dis | clr_all);
        rxu_d  = set_wins(rxu_q, rd_data & rx_empty, dis | clr_all);
        // The reason is captured with the abort and kept until the next one.
        why_d  = I_TX_ABORT ? I_ABORT_REASON : why_q;
        // The clock is held until software supplies the byte.
        hold_d = set_wins(hold_q, I_RD_REQ, tx_push);
    end

    // Flag registers.
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            mask_q <= i2c_intr_pkg::MASK_RST;
            gc_q   <= 1'b0;
            st_q   <= 1'b0;
            sp_q   <= 1'b0;
            act_q  <= 1'b0;
            rxd_q  <= 1'b0;
            ab_q   <= 1'b0;
            rr_q   <= 1'b0;
            txo_q  <= 1'b0;
            rxo_q  <= 1'b0;
            rxu_q  <= 1'b0;
            why_q  <= 16'h0000;
            hold_q <= 1'b0;
        end else begin
            mask_q <= mask_d;
            gc_q   <= gc_d;
            st_q   <= st_d;
            sp_q   <= sp_d;
            act_q  <= act_d;
            rxd_q  <= rxd_d;
            ab_q   <= ab_d;
            rr_q   <= rr_d;
            txo_q  <= txo_d;
            rxo_q  <= rxo_d;
            rxu_q  <= rxu_d;
            why_q  <= why_d;
            hold_q <= hold_d;
        end
    end

    // ------------------------------------------------------------
    // Bus answer and output registers.
    // ------------------------------------------------------------
    logic [31:0] prdata_d;           // Read data for the access phase.
    logic        pready_d, perr_d;   // Handshake for the access phase.
    logic [8:0]  txd_d;              // Byte handed to the engine.
    logic        txs_d, intr_d;      // Fetch strobe and interrupt.

    // Read data is sampled in setup, so a clear-on-read returns the old flag.
    always_comb begin
        prdata_d = O_PRDATA;
        pready_d = setup;
        perr_d   = 1'b0;
        if (setup) begin
            prdata_d = 32'h00000000;
            case (I_PADDR)
                i2c_intr_pkg::ADDR_DATA_CMD:  prdata_d = {23'h000000, rx_head};
                i2c_intr_pkg::ADDR_MASKED:    prdata_d = {16'h0000, masked};
                i2c_intr_pkg::ADDR_MASK:      prdata_d = {16'h0000, mask_q};
                i2c_intr_pkg::ADDR_RAW:       prdata_d = {16'h0000, raw};
                i2c_intr_pkg::ADDR_CLR_ALL:   prdata_d = {31'h00000000, |masked};
                i2c_intr_pkg::ADDR_CLR_RDREQ: prdata_d = {31'h00000000, rr_q};
                i2c_intr_pkg::ADDR_CLR_ABORT: prdata_d = {31'h00000000, ab_q};
                i2c_intr_pkg::ADDR_CLR_ACT:   prdata_d = {31'h00000000, act_q};
                i2c_intr_pkg::ADDR_CLR_GC:    prdata_d = {31'h00000000, gc_q};
                i2c_intr_pkg::ADDR_ABORT_WHY: prdata_d = {16'h0000, why_q};
                // Unmapped addresses answer with an error and zero data.
                default:                      perr_d   = 1'b1;
            endcase
        end
        txd_d  = tx_pop ? tx_head : O_TX_DATA;
        txs_d  = tx_pop;
        intr_d = |masked;
    end

    // Output registers.
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            O_PRDATA    <= 32'h00000000;
            O_PREADY    <= 1'b0;
            O_PSLVERR   <= 1'b0;
            O_TX_DATA   <= 9'h000;
            O_TX_STROBE <= 1'b0;
            O_INTR      <= 1'b0;
        end else begin
            O_PRDATA    <= prdata_d;
            O_PREADY    <= pready_d;
            O_PSLVERR   <= perr_d;
            O_TX_DATA   <= txd_d;
            O_TX_STROBE <= txs_d;
            O_INTR      <= intr_d;
        end
    end

    assign O_SCL_HOLD = hold_q;

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RESET);

    mask_reset_a: assert property ($fell(I_RESET) |-> mask_q == 16'h08FF)
        else $error("mask reset value wrong");
    broadcast_address_seen_a: assert property (I_BROADCAST_ADDRESS_SEEN_ACK |=> raw[11])
        else $error("general call flag not set");
    start_seen_a: assert property (I_START_SEEN |=> st_q)
        else $error("start flag not set");
    stop_seen_a: assert property (I_STOP_SEEN |=> sp_q)
        else $error("stop flag not set");
    act_sticky_a: assert property (act_q && I_CTRL_ENABLE && !clr_act && !clr_all |=> act_q)
        else $error("activity flag dropped");
    slave_done_a: assert property (I_SLV_TX_NACK |=> raw[7])
        else $error("slave transmit done not set");
    abort_flush_a: assert property (ab_q |=> tx_cnt == 6'h00)
        else $error("transmit buffer not flushed on abort");
    scl_hold_a: assert property (I_RD_REQ |=> O_SCL_HOLD && raw[5])
        else $error("read request did not hold the clock");
    rdreq_clear_a: assert property (clr_rd && !I_RD_REQ |=> !rr_q)
        else $error("read request flag not cleared");
    tx_over_a: assert property (wr_data && tx_full && !ab_q && I_CTRL_ENABLE |=> txo_q)
        else $error("transmit overflow not flagged");
    intr_or_a: assert property (|masked |=> O_INTR)
        else $error("interrupt output missed a source");

endmodule // i2c_intr_status

`default_nettype wire

// ==== tb/i2c_remote_model.sv ====
// Behavioural model of the byte engine that faces a remote I2C master or slave.
// Assumes the block samples every event on the rising edge of the shared clock.
`timescale 1ns/10ps
`default_nettype none

module i2c_remote_model (
    // Clock.
    input  wire logic        i_clk,
    // Event pulses toward the block.
    output logic             o_gc,
    output logic             o_start,
    output logic             o_stop,
    output logic             o_busy,
    output logic             o_nack,
    output logic             o_abort,
    output logic [15:0]      o_reason,
    output logic             o_rd_req,
    // Data toward the block.
    output logic             o_rx_valid,
    output logic [7:0]       o_rx_data,
    output logic             o_tx_pop
);
    // --------------------------------------------------------
    // Event launcher.
    // --------------------------------------------------------
    // Every line is quiet at time zero so the block never sees an unknown.
    initial begin
        {o_gc, o_start, o_stop, o_busy, o_nack, o_abort, o_rd_req, o_rx_valid, o_tx_pop} = 9'h000;
        o_reason  = 16'h0000;
        o_rx_data = 8'h00;
    end

    // Pulses one event for a full cycle, launched on the falling edge.
    task automatic fire(input logic [3:0] kind, input logic [15:0] v);
        @(negedge i_clk);
        o_reason  = v;
        o_rx_data = v[7:0];
        case (kind)
            4'h0: o_gc = 1'b1;
            4'h1: o_start = 1'b1;
            4'h2: o_stop = 1'b1;
            4'h3: o_busy = 1'b1;
            4'h4: o_nack = 1'b1;
            4'h5: o_abort = 1'b1;
            4'h6: o_rd_req = 1'b1;
            4'h7: o_rx_valid = 1'b1;
            default: o_tx_pop = 1'b1;
        endcase
        @(negedge i_clk);
        {o_gc, o_start, o_stop, o_busy, o_nack, o_abort, o_rd_req, o_rx_valid, o_tx_pop} = 9'h000;
        // Unqualified lines flip so a stale value can never pass for a fresh one.
        o_reason  = ~v;
        o_rx_data = ~v[7:0];
    endtask
endmodule // i2c_remote_model

`default_nettype wire

// ==== tb/test_i2c_interrupt_mask_and_raw_status.sv ====
// Self-checking bench for the I2C interrupt mask and raw status block.
// Assumes the remote model pulses the engine events and APB is driven here.
`timescale 1ns/10ps
`default_nettype none

module test_i2c_interrupt_mask_and_raw_status;
    // --------------------------------------------------------
    // Signals.
    // --------------------------------------------------------
    typedef struct {logic [3:0] kind; logic [31:0] raw; logic [31:0] intr;} row_t;
    logic        clk = 1'b0, rst = 1'b1, en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, txd = 32'h0;
    logic        pready, pslverr, er, gc, st, sp, bz, nk, ab, rq, rxv, pop, strobe, hold, intr;
    logic [15:0] why;
    logic [7:0]  rxd;
    logic [8:0]  txdata;
    int          bad_count = 0, total_checks = 0, strobes = 0, cycles = 0;
    row_t        rows[7] = '{'{4'h0, 32'h800, 32'h1}, '{4'h1, 32'h400, 32'h0},
                            '{4'h2, 32'h200, 32'h0}, '{4'h3, 32'h100, 32'h0},
                            '{4'h4, 32'h080, 32'h1}, '{4'h5, 32'h040, 32'h1},
                            '{4'h6, 32'h020, 32'h1}};

    always #4 clk = ~clk;

    i2c_intr_status DUT (.I_REF_CLK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_CTRL_ENABLE(en), .I_BROADCAST_ADDRESS_SEEN_ACK(gc),
        .I_START_SEEN(st), .I_STOP_SEEN(sp), .I_BUS_BUSY(bz), .I_SLV_TX_NACK(nk),
        .I_TX_ABORT(ab), .I_ABORT_REASON(why), .I_RD_REQ(rq), .I_RX_VALID(rxv),
        .I_RX_DATA(rxd), .I_TX_POP(pop), .O_TX_DATA(txdata), .O_TX_STROBE(strobe),
        .O_SCL_HOLD(hold), .O_INTR(intr));

    i2c_remote_model far (.i_clk(clk), .o_gc(gc), .o_start(st), .o_stop(sp), .o_busy(bz),
        .o_nack(nk), .o_abort(ab), .o_reason(why), .o_rd_req(rq), .o_rx_valid(rxv),
        .o_rx_data(rxd), .o_tx_pop(pop));

    // Records every fetched transmit entry; counting strobes catches a double fetch.
    // Sampled mid-cycle, where the registered strobe has settled.
    always @(negedge clk) begin
        if (strobe === 1'b1) begin
            strobes <= strobes + 1;
            txd     <= {23'h0, txdata};
        end
    end

    // Watchdog: the sequence needs well under two thousand cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            final_report();
        end
    end

    // --------------------------------------------------------
    // Tasks.
    // --------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; read data and error are taken in the ready cycle.
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(negedge clk);
        psel   = 1'b1;
        pwrite = w;
        paddr  = a;
        pwdata = d;
        @(negedge clk);
        penable = 1'b1;
        n = 0;
        while (pready !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        chk({31'h0, pready}, 32'h1);
        rd = prdata;
        er = pslverr;
        @(negedge clk);
        psel    = 1'b0;
        penable = 1'b0;
    endtask

    task automatic final_report();
        $display("Checks made %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // --------------------------------------------------------
    // Main sequence.
    // --------------------------------------------------------
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        apb(1'b0, i2c_intr_pkg::ADDR_MASK, 32'h0);
        chk(rd, 32'h08FF);
        apb(1'b1, i2c_intr_pkg::ADDR_MASK, 32'hFFFFFFFF);
        apb(1'b0, i2c_intr_pkg::ADDR_MASK, 32'h0);
        chk(rd, 32'h0FFF);
        apb(1'b1, i2c_intr_pkg::ADDR_MASK, 32'h08FF);
        // Each event alone must raise exactly its own flag; interrupt follows the mask.
        foreach (rows[i]) begin
            far.fire(rows[i].kind, 16'h0000);
            apb(1'b0, i2c_intr_pkg::ADDR_RAW, 32'h0);
            chk(rd, rows[i].raw);
            chk({31'h0, intr}, rows[i].intr);
            apb(1'b0, i2c_intr_pkg::ADDR_CLR_ALL, 32'h0);
            chk(rd, rows[i].intr);
        end
        chk({31'h0, hold}, 32'h1);
        far.fire(4'h0, 16'h0000);
        apb(1'b0, i2c_intr_pkg::ADDR_CLR_GC, 32'h0);
        chk(rd, 32'h1);
        far.fire(4'h6, 16'h0000);
        apb(1'b0, i2c_intr_pkg::ADDR_CLR_RDREQ, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, i2c_intr_pkg::ADDR_RAW, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, i2c_intr_pkg::ADDR_DATA_CMD, 32'h1A5);
        far.fire(4'h8, 16'h0000);
        repeat (2) @(negedge clk);
        chk({31'h0, hold}, 32'h0);
        chk(txd, 32'h1A5);
        // Abort with a queued byte: the queue is flushed and stays shut until cleared.
        apb(1'b1, i2c_intr_pkg::ADDR_DATA_CMD, 32'h022);
        far.fire(4'h5, 16'h0123);
        apb(1'b1, i2c_intr_pkg::ADDR_DATA_CMD, 32'h033);
        far.fire(4'h8, 16'h0000);
        repeat (2) @(negedge clk);
        chk(strobes, 32'h1);
        apb(1'b0, i2c_intr_pkg::ADDR_ABORT_WHY, 32'h0);
        chk(rd, 32'h0123);
        apb(1'b0, i2c_intr_pkg::ADDR_CLR_ABORT, 32'h0);
        apb(1'b1, i2c_intr_pkg::ADDR_DATA_CMD, 32'h044);
        far.fire(4'h8, 16'h0000);
        repeat (2) @(negedge clk);
        chk(txd, 32'h044);
        far.fire(4'h7, 16'h005A);
        apb(1'b0, i2c_intr_pkg::ADDR_DATA_CMD, 32'h0);
        chk(rd, 32'h5A);
        // Both buffers are pushed one entry past full.
        repeat (33) apb(1'b1, i2c_intr_pkg::ADDR_DATA_CMD, 32'h011);
        repeat (33) far.fire(4'h7, 16'h0066);
        apb(1'b0, i2c_intr_pkg::ADDR_RAW, 32'h0);
        chk(rd, 32'h00A);
        apb(1'b1, i2c_intr_pkg::ADDR_MASK, 32'h00000002);
        apb(1'b0, i2c_intr_pkg::ADDR_MASKED, 32'h0);
        chk(rd, 32'h002);
        far.fire(4'h3, 16'h0000);
        en = 1'b0;
        @(negedge clk);
        en = 1'b1;
        apb(1'b0, i2c_intr_pkg::ADDR_RAW, 32'h0);
        chk(rd, 32'h0);
        far.fire(4'h3, 16'h0000);
        apb(1'b0, i2c_intr_pkg::ADDR_CLR_ACT, 32'h0);
        apb(1'b0, i2c_intr_pkg::ADDR_RAW, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 32'h50001300, 32'h0);
        chk({31'h0, er}, 32'h1);
        final_report();
    end
endmodule // test_i2c_interrupt_mask_and_raw_status

`default_nettype wire
